// *** verilog/eeba_pkg.sv ***
package eeba_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] NV_CTRL_OFFSET = 8'h40;
    localparam logic       NV_CTRL_BANK   = 1'b1;
    localparam logic [7:0] NV_ADDR_OFFSET = 8'h1E;
    localparam logic [7:0] NV_DATA_OFFSET = 8'h1F;
    localparam logic       NV_DATA_BANK   = 1'b0;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int         STORE_EN_BIT    = 3;
    localparam int         STORE_START_BIT = 2;
    localparam int         READ_EN_BIT     = 1;
    localparam int         READ_BEGIN_BIT  = 0;
    localparam int         ADDR_BITS       = 6;
    localparam int         STORE_DEPTH     = 64;
    localparam logic [7:0] NV_ADDR_RESET   = 8'h00;
    localparam logic [7:0] NV_DATA_RESET   = 8'h00;
    localparam logic [7:0] NV_CTRL_RESET   = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ   = 20_000_000;
    localparam int TICK_TIME_NS  = 1000;
    localparam int TICK_CYCLES   = (CLK_FREQ_HZ / 1_000_000) * TICK_TIME_NS / 1000;
    localparam int WRITE_TIME_US = 2000;
    localparam int WRITE_TICKS   = WRITE_TIME_US * 1000 / TICK_TIME_NS;
    localparam int READ_CYCLES   = 4;

    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b100
    } eeba_state_t;

endpackage

// *** verilog/eeba_store.sv ***
module eeba_store #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 8,
    parameter int AW    = 6
) (
    input  wire logic             core_clk, // System clock
    input  wire logic             we,       // Write strobe
    input  wire logic [AW-1:0]    waddr,    // Write location
    input  wire logic [WIDTH-1:0] wdata,    // Write byte
    input  wire logic [AW-1:0]    raddr,    // Read location
    output logic      [WIDTH-1:0] rdata     // Registered read byte
);
    // Contents survive reset: this is the non-volatile array
    logic [WIDTH-1:0] mem_reg [DEPTH];

    if (DEPTH > (1 << AW)) begin : g_bad_depth
        $error("eeba_store: DEPTH exceeds address range");
    end

    always_ff @(posedge core_clk)
    begin
        if (we)
        begin
            mem_reg[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk)
    begin
        rdata <= mem_reg[raddr];
    end

endmodule

// *** verilog/eeba_top.sv ***
// Operation
// - The store holds 64 bytes and each operation moves exactly one byte.
// - The store is not in memory space; access is via address and data in bank 0, control in bank 1.
// - nv_address holds a 6-bit location, resets to zero, and bits 7 to 6 read as zero.
// - nv_data is a read/write byte that resets to zero and carries the transferred byte.
// - nv_control bits 7 to 4 read as zero and the four low bits are read/write, resetting to zero; the code sets bits 2 and 0 only on an accepted start.
// - store_enable (bit 3) must be set before a write; while it is low writes are blocked.
// - Setting store_start (bit 2) begins a write of nv_data into the location in nv_address.
// - The device clears store_start when the write ends, so zero means finished.
// - Setting store_start without store_enable already high does nothing.
// - read_enable (bit 1) enables reads when one and must be set before a read.
// - read_begin (bit 0) starts a read only if read_enable is high, clears at the end, and the byte stays in nv_data.
// - A finished write sets nv_done_flag and the multi-function request; only software clears nv_done_flag.
module eeba_top
    import eeba_pkg::*;
#(
    parameter int WR_TICKS  = eeba_pkg::WRITE_TICKS, // Timer ticks per write
    parameter int TICK_DIV  = eeba_pkg::TICK_CYCLES, // Clocks per timer tick
    parameter int RD_CYCLES = eeba_pkg::READ_CYCLES  // Clocks per read
) (
    input  wire logic       core_clk,      // System clock, 20 MHz
    input  wire logic       reset,         // Synchronous reset, active high
    input  wire logic [7:0] sfr_addr,      // Special register address
    input  wire logic       sfr_bank,      // Resolved data bank of the access
    input  wire logic       sfr_wr,        // Write strobe, one cycle
    input  wire logic [7:0] sfr_wdata,     // Write byte
    output logic      [7:0] sfr_rd_data,   // Read byte, one cycle after address
    input  wire logic       nv_done_clear, // Software clear of done flag
    output logic            nv_done_flag,  // Write done flag, sticky
    output logic            mf_flag_set    // Pulse to multi-function request
);
    import eeba_pkg::*;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (RD_CYCLES < 2 || RD_CYCLES > 255) begin : g_bad_rd
        $error("eeba_top: RD_CYCLES must be 2..255");
    end
    if (WR_TICKS < 1 || WR_TICKS > 65535) begin : g_bad_wr
        $error("eeba_top: WR_TICKS must be 1..65535");
    end
    if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_tick
        $error("eeba_top: TICK_DIV must be 1..65535");
    end

    localparam int RD_MAX = RD_CYCLES + 1;

    eeba_state_t              state_reg;
    logic [ADDR_BITS-1:0]     nv_address_reg;
    logic [7:0]               nv_data_reg;
    logic                     store_enable_reg;
    logic                     store_start_reg;
    logic                     read_enable_reg;
    logic                     read_begin_reg;
    logic [ADDR_BITS-1:0]     lat_addr_reg;
    logic [7:0]               lat_data_reg;
    logic [15:0]              tick_cnt_reg;
    logic [15:0]              wr_cnt_reg;
    logic [7:0]               rd_cnt_reg;
    logic                     tick;
    logic                     ctrl_wr;
    logic                     wr_accept;
    logic                     rd_accept;
    logic                     wr_end;
    logic                     rd_end;
    logic [7:0]               store_rdata;

    function automatic logic hit(input logic [7:0] a, input logic b,
                                 input logic [7:0] off, input logic ob);
        hit = (a == off) && (b == ob);
    endfunction

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    // Control sits in bank one only; bank zero at 40H never reaches it
    assign ctrl_wr = sfr_wr && hit(sfr_addr, sfr_bank, NV_CTRL_OFFSET, NV_CTRL_BANK);

    // Both starts in one write is refused outright
    assign wr_accept = ctrl_wr && sfr_wdata[STORE_START_BIT] && !sfr_wdata[READ_BEGIN_BIT]
                       && store_enable_reg && (state_reg == ST_IDLE);
    assign rd_accept = ctrl_wr && sfr_wdata[READ_BEGIN_BIT] && !sfr_wdata[STORE_START_BIT]
                       && read_enable_reg && (state_reg == ST_IDLE);

    assign wr_end = (state_reg == ST_WRITE) && tick && (wr_cnt_reg == 16'h0001);
    assign rd_end = (state_reg == ST_READ) && (rd_cnt_reg == 8'h00);

    // ------------------------------------------------------------
    // Write timer
    // ------------------------------------------------------------
    // Free-running prescaler: its phase is unrelated to the start,
    // so a write lasts between WR_TICKS-1 and WR_TICKS full ticks
    always_ff @(posedge core_clk)
    begin
        if (reset || tick)
            tick_cnt_reg <= 16'h0000;
        else
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
    assign tick = (tick_cnt_reg == 16'(TICK_DIV - 1));

    always_ff @(posedge core_clk)
    begin
        if (reset)
            wr_cnt_reg <= 16'h0000;
        else if (wr_accept)
            wr_cnt_reg <= 16'(WR_TICKS);
        else if ((state_reg == ST_WRITE) && tick)
            wr_cnt_reg <= wr_cnt_reg - 16'h0001;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            rd_cnt_reg <= 8'h00;
        else if (rd_accept)
            rd_cnt_reg <= 8'(RD_CYCLES - 1);
        else if (state_reg == ST_READ)
            rd_cnt_reg <= rd_cnt_reg - 8'h01;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
            state_reg <= ST_IDLE;
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (wr_accept)
                        state_reg <= ST_WRITE;
                    else if (rd_accept)
                        state_reg <= ST_READ;
                end
                ST_WRITE:
                begin
                    if (wr_end)
                        state_reg <= ST_IDLE;
                end
                ST_READ:
                begin
                    if (rd_end)
                        state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Operands are frozen at the start so later register writes
    // cannot corrupt a cycle in flight
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            lat_addr_reg <= '0;
            lat_data_reg <= 8'h00;
        end
        else if (wr_accept || rd_accept)
        begin
            lat_addr_reg <= nv_address_reg;
            lat_data_reg <= nv_data_reg;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            store_enable_reg <= NV_CTRL_RESET[STORE_EN_BIT];
            read_enable_reg  <= NV_CTRL_RESET[READ_EN_BIT];
        end
        else if (ctrl_wr)
        begin
            store_enable_reg <= sfr_wdata[STORE_EN_BIT];
            read_enable_reg  <= sfr_wdata[READ_EN_BIT];
        end
    end

    // Start bits are set only by an accepted start, cleared only by hardware
    always_ff @(posedge core_clk)
    begin
        if (reset)
            store_start_reg <= NV_CTRL_RESET[STORE_START_BIT];
        else if (wr_accept)
            store_start_reg <= 1'b1;
        else if (wr_end)
            store_start_reg <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            read_begin_reg <= NV_CTRL_RESET[READ_BEGIN_BIT];
        else if (rd_accept)
            read_begin_reg <= 1'b1;
        else if (rd_end)
            read_begin_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // Address and data registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
            nv_address_reg <= NV_ADDR_RESET[ADDR_BITS-1:0];
        else if (sfr_wr && hit(sfr_addr, sfr_bank, NV_ADDR_OFFSET, NV_DATA_BANK))
            nv_address_reg <= sfr_wdata[ADDR_BITS-1:0];
    end

    // Read result wins over a software write in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (reset)
            nv_data_reg <= NV_DATA_RESET;
        else if (rd_end)
            nv_data_reg <= store_rdata;
        else if (sfr_wr && hit(sfr_addr, sfr_bank, NV_DATA_OFFSET, NV_DATA_BANK))
            nv_data_reg <= sfr_wdata;
    end

    eeba_store #(
        .DEPTH (STORE_DEPTH),
        .WIDTH (8),
        .AW    (ADDR_BITS)
    ) u_store (
        .core_clk (core_clk),
        .we       (wr_end),
        .waddr    (lat_addr_reg),
        .wdata    (lat_data_reg),
        .raddr    (lat_addr_reg),
        .rdata    (store_rdata)
    );

    // ------------------------------------------------------------
    // Done flag and read-back
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
            nv_done_flag <= 1'b0;
        else if (wr_end)
            nv_done_flag <= 1'b1;
        else if (nv_done_clear)
            nv_done_flag <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            mf_flag_set <= 1'b0;
        else
            mf_flag_set <= wr_end;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            sfr_rd_data <= 8'h00;
        else if (hit(sfr_addr, sfr_bank, NV_ADDR_OFFSET, NV_DATA_BANK))
            sfr_rd_data <= {2'b00, nv_address_reg};
        else if (hit(sfr_addr, sfr_bank, NV_DATA_OFFSET, NV_DATA_BANK))
            sfr_rd_data <= nv_data_reg;
        else if (hit(sfr_addr, sfr_bank, NV_CTRL_OFFSET, NV_CTRL_BANK))
            sfr_rd_data <= {4'h0, store_enable_reg, store_start_reg,
                            read_enable_reg, read_begin_reg};
        else
            sfr_rd_data <= 8'h00;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_wr_blocked_off: assert property (ctrl_wr && sfr_wdata[STORE_START_BIT] && !store_enable_reg
        |=> !store_start_reg && (state_reg != ST_WRITE)) else $error("write began while disabled");
    a_wr_enable_held: assert property ($rose(store_start_reg) |-> $past(store_enable_reg))
        else $error("write start without prior enable");
    a_rd_needs_enable: assert property (ctrl_wr && sfr_wdata[READ_BEGIN_BIT] && !read_enable_reg
        |=> !read_begin_reg) else $error("read began while disabled");
    a_wr_busy_bit: assert property ((state_reg == ST_WRITE) |-> store_start_reg)
        else $error("write bit low during write");
    a_wr_end_flags: assert property (wr_end |=> !store_start_reg && nv_done_flag && mf_flag_set
        ##1 !mf_flag_set) else $error("write end effects wrong");
    a_rd_latency: assert property (rd_accept |=> read_begin_reg ##[1:RD_MAX] !read_begin_reg)
        else $error("read not finished in time");
    a_rd_data_load: assert property (rd_end |=> nv_data_reg == $past(store_rdata))
        else $error("read byte not loaded");
    a_addr_upper_zero: assert property (hit($past(sfr_addr), $past(sfr_bank), NV_ADDR_OFFSET,
        NV_DATA_BANK) |-> sfr_rd_data[7:6] == 2'b00) else $error("address upper bits set");
    a_ctrl_upper_zero: assert property (hit($past(sfr_addr), $past(sfr_bank), NV_CTRL_OFFSET,
        NV_CTRL_BANK) |-> sfr_rd_data[7:4] == 4'h0) else $error("control upper bits set");
    a_done_set_wins: assert property (wr_end && nv_done_clear |=> nv_done_flag)
        else $error("done flag lost to clear");
    a_bank0_no_ctrl: assert property (sfr_wr && sfr_addr == NV_CTRL_OFFSET && !sfr_bank
        |-> !ctrl_wr) else $error("bank zero reached control");

    // Write length can run to many thousand clocks, so cover the end itself
    c_write_done: cover property (wr_end ##1 (nv_done_flag && !store_start_reg));
    c_read_done: cover property (rd_accept ##[1:RD_MAX] rd_end);
    c_write_blocked: cover property (ctrl_wr && sfr_wdata[STORE_START_BIT] && !store_enable_reg);
    c_set_clear_clash: cover property (wr_end && nv_done_clear);

endmodule

// *** dv/eeba_top_tb.sv ***
module eeba_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import eeba_pkg::*;

    // ------------------------------------------------------------
    // Shortened timing so a write lasts a handful of clocks
    // ------------------------------------------------------------
    localparam int WR_T  = 3;
    localparam int DIV   = 2;
    localparam int RD_C  = 4;
    localparam int LIMIT = 3000;

    logic       core_clk      = 1'b0;
    logic       reset         = 1'b1;
    logic [7:0] sfr_addr      = 8'h00;
    logic       sfr_bank      = 1'b0;
    logic       sfr_wr        = 1'b0;
    logic [7:0] sfr_wdata     = 8'h00;
    logic [7:0] sfr_rd_data;
    logic       nv_done_clear = 1'b0;
    logic       nv_done_flag;
    logic       mf_flag_set;
    logic [7:0] q;
    logic [7:0] addr_t [3] = '{8'h00, 8'h3F, 8'h05};
    logic [7:0] dat_t  [3] = '{8'hC3, 8'h3C, 8'h5A};
    int         err_count  = 0;
    int         num_checks = 0;
    int         cyc        = 0;
    int         mf_cnt     = 0;
    int         mf_cyc     = 0;
    int         t0         = 0;
    int         n_wr       = 0;

    always #25 core_clk = ~core_clk;

    eeba_top #(
        .WR_TICKS  (WR_T),
        .TICK_DIV  (DIV),
        .RD_CYCLES (RD_C)
    ) dut_u (
        .core_clk      (core_clk),
        .reset         (reset),
        .sfr_addr      (sfr_addr),
        .sfr_bank      (sfr_bank),
        .sfr_wr        (sfr_wr),
        .sfr_wdata     (sfr_wdata),
        .sfr_rd_data   (sfr_rd_data),
        .nv_done_clear (nv_done_clear),
        .nv_done_flag  (nv_done_flag),
        .mf_flag_set   (mf_flag_set)
    );

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Sees pre-edge values, so the pulse and the flag are compared in one cycle
    always @(posedge core_clk)
    begin
        cyc = cyc + 1;
        if (mf_flag_set === 1'b1)
        begin
            mf_cnt = mf_cnt + 1;
            mf_cyc = cyc;
            chk({7'h00, nv_done_flag}, 8'h01);
        end
        if (cyc >= LIMIT)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic b, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr  <= a;
        sfr_bank  <= b;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge core_clk);
        sfr_wr    <= 1'b0;
    endtask

    // Answer lands one edge after the address; look just past that edge
    task automatic rd(input logic [7:0] a, input logic b, output logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_bank <= b;
        @(posedge core_clk);
        #1 d = sfr_rd_data;
    endtask

    task automatic rdc(input logic [7:0] a, input logic b, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, b, v);
        chk(v, exp);
    endtask

    task automatic nv_write(input logic [7:0] a, input logic [7:0] d);
        int dur;
        wr(NV_ADDR_OFFSET, NV_DATA_BANK, a);
        wr(NV_DATA_OFFSET, NV_DATA_BANK, d);
        wr(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h08);
        wr(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h0C);
        #1 t0 = cyc;
        rdc(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h0C);
        for (int i = 0; i < 200 && nv_done_flag !== 1'b1; i++)
            @(posedge core_clk);
        @(posedge core_clk);
        #1 dur = mf_cyc - t0;
        chk({7'h00, nv_done_flag}, 8'h01);
        chk((dur >= (WR_T - 1) * DIV && dur <= WR_T * DIV + 1) ? 8'h01 : 8'h00, 8'h01);
        rdc(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h08);
        rdc(NV_DATA_OFFSET, NV_DATA_BANK, d);
        chk({7'h00, nv_done_flag}, 8'h01);
        @(posedge core_clk);
        nv_done_clear <= 1'b1;
        @(posedge core_clk);
        nv_done_clear <= 1'b0;
        #1 chk({7'h00, nv_done_flag}, 8'h00);
        n_wr++;
    endtask

    task automatic nv_read(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        wr(NV_ADDR_OFFSET, NV_DATA_BANK, a);
        wr(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h02);
        wr(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h03);
        rdc(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h03);
        v = 8'hFF;
        for (int i = 0; i < RD_C + 4 && v[READ_BEGIN_BIT] !== 1'b0; i++)
            rd(NV_CTRL_OFFSET, NV_CTRL_BANK, v);
        chk(v, 8'h02);
        rdc(NV_DATA_OFFSET, NV_DATA_BANK, exp);
        repeat (3) @(posedge core_clk);
        rdc(NV_DATA_OFFSET, NV_DATA_BANK, exp);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rdc(NV_ADDR_OFFSET, NV_DATA_BANK, 8'h00);
        rdc(NV_DATA_OFFSET, NV_DATA_BANK, 8'h00);
        rdc(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h00);
        chk({7'h00, nv_done_flag}, 8'h00);
        wr(NV_ADDR_OFFSET, NV_DATA_BANK, 8'hFF);
        rdc(NV_ADDR_OFFSET, NV_DATA_BANK, 8'h3F);
        wr(NV_DATA_OFFSET, NV_DATA_BANK, 8'hA5);
        rdc(NV_DATA_OFFSET, NV_DATA_BANK, 8'hA5);
        wr(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'hF0);
        rdc(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h00);
        wr(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h0A);
        rdc(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h0A);
        // Both start bits in one byte: neither may start
        wr(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h0F);
        rdc(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h0A);
        wr(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h00);
        // Control offset seen from bank 0 is not the control register
        wr(NV_CTRL_OFFSET, NV_DATA_BANK, 8'h0A);
        rdc(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h00);
        rdc(NV_CTRL_OFFSET, NV_DATA_BANK, 8'h00);
        rdc(8'h55, NV_DATA_BANK, 8'h00);
        for (int k = 0; k < 3; k++)
            nv_write(addr_t[k], dat_t[k]);
        // Start without enable must leave location 05 alone
        wr(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h00);
        wr(NV_ADDR_OFFSET, NV_DATA_BANK, 8'h05);
        wr(NV_DATA_OFFSET, NV_DATA_BANK, 8'h77);
        wr(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h04);
        rdc(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h00);
        repeat (WR_T * DIV + 4) @(posedge core_clk);
        #1 chk({7'h00, nv_done_flag}, 8'h00);
        // Read start without read enable does nothing
        wr(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h01);
        rdc(NV_CTRL_OFFSET, NV_CTRL_BANK, 8'h00);
        rdc(NV_DATA_OFFSET, NV_DATA_BANK, 8'h77);
        for (int k = 0; k < 3; k++)
            nv_read(addr_t[k], dat_t[k]);
        chk(8'(mf_cnt), 8'(n_wr));
        tally_and_finish();
    end
endmodule
